/* dv/tb_tmr_core.sv */
// self-checking bench for the reload/compare timer
`timescale 1ns/1ps
module tb_tmr_core;
    import tmr_pkg::*;
    logic clk = 0, rst_n = 0, flag, irq, pend = 0;
    bus_req_s bus = '0;
    cap_evt_s cap = '0;
    logic [7:0] rdata, m, exp_q[$];
    logic [15:0] rv, cv, ex;
    int mismatches = 0, cmp_count = 0, k, ch, md;
    int ratio[8] = '{1, 4, 16, 32, 64, 128, 256, 512};
    always #2.5 clk = ~clk;
    tmr_core dut (.SYS_CLK(clk), .ARST_N(rst_n), .BUS(bus), .RDATA(rdata), .CAP(cap),
        .FLAG(flag), .IRQ(irq));
    task automatic check(logic [7:0] seen, logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
        end
    endtask
    always @(posedge clk) begin
        if (pend) check(rdata, exp_q.pop_front());
        pend <= bus.rd;
    end
    task automatic op(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, w, !w};
        if (!w) exp_q.push_back(d);
    endtask
    task automatic idle(int n);
        repeat (n) op(1, 8'hE0, 8'h00);
    endtask
    task automatic wcnt(logic [15:0] v);
        op(1, 8'hCC, v[7:0]);
        op(1, 8'hCD, v[15:8]);
    endtask
    task automatic rcnt(logic [15:0] v);
        op(0, 8'hCC, v[7:0]);
        op(0, 8'hCD, v[15:8]);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hF9057075));
        repeat (6) @(posedge clk);
        rst_n <= 1;
        for (k = 0; k < 5; k++) op(0, 8'hC9 + k, 8'h00);
        op(0, 8'hE0, 8'h00);
        $display("reset values done");
        for (k = 0; k < 8; k++) begin
            wcnt(0);
            op(1, 8'hC9, {1'b0, k[2:0], 4'h0});
            op(1, 8'hC8, 8'h04);
            idle(3 * ratio[k] - 1);
            op(1, 8'hC8, 8'h00);
            rcnt(3);
        end
        $display("prescale done");
        for (k = 0; k < 2; k++) begin
            rv = $urandom;
            op(1, 8'hCA, rv[7:0]);
            op(1, 8'hCB, rv[15:8]);
            op(1, 8'hC9, {k[0], 7'h00});
            wcnt(16'hFFFF);
            op(1, 8'hC8, 8'h04);
            op(1, 8'hC8, 8'h00);
            rcnt(k ? rv : 16'h0000);
            op(0, 8'hC8, 8'h80);
        end
        op(0, 8'hD0, 8'h01);
        op(1, 8'hD1, 8'h01);
        idle(3);
        check({7'h00, irq}, 8'h01);
        op(1, 8'hD0, 8'h01);
        idle(2);
        check({7'h00, irq}, 8'h00);
        op(1, 8'hD1, 8'h00);
        $display("overflow done");
        for (k = 0; k < 16; k++) begin
            cv = $urandom;
            m = $urandom & 8'h8B;
            md = $urandom_range(1);
            ch = $urandom_range(2);
            op(1, 8'hC8, {7'h00, md[0]});
            op(1, 8'hC9, m);
            wcnt(cv);
            op(1, 8'hE0, 8'h00);
            cap <= 3'b001 << ch;
            @(posedge clk);
            cap <= '0;
            ex = (!md && m[3]) ? 16'h0000 : (!md && m[7] && m[1:0] == ch + 1) ? rv : cv;
            rcnt(ex);
        end
        $display("capture done");
        for (k = 0; k < 3; k++) begin
            cv = $urandom & 16'h7FFF;
            op(1, 8'hCA, cv[7:0]);
            op(1, 8'hCB, cv[15:8]);
            op(1, 8'hC9, k == 1 ? 8'h00 : 8'h04);
            op(1, 8'hC8, {7'h00, k != 2});
            wcnt(cv);
            op(1, 8'hC8, {5'h00, 1'b1, 1'b0, k != 2});
            op(1, 8'hC8, {7'h00, k != 2});
            rcnt(k == 0 ? 16'h0000 : cv + 1);
            op(0, 8'hC8, k < 2 ? 8'h81 : 8'h00);
        end
        $display("compare done");
        idle(3);
        wrap_up;
    end
endmodule

/* dv/tmr_core_asserts.sv */
// checker for the timer register port, flag and interrupt
`timescale 1ns/1ps
module tmr_core_asserts (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // watched ports
    input wire tmr_pkg::bus_req_s BUS,
    input wire logic [7:0] RDATA,
    input wire tmr_pkg::cap_evt_s CAP,
    input wire logic FLAG,
    input wire logic IRQ
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);
    wire hit = (BUS.addr >= 8'hC8 && BUS.addr <= 8'hCD) || BUS.addr[7:1] == 7'h68;
    wire rd_ctl = BUS.rd && BUS.addr == 8'hC8;
    wire clr = BUS.wr && BUS.addr == 8'hC8 && !BUS.wdata[7];
    property p_hold; FLAG && !clr |=> FLAG; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_frd; rd_ctl |=> RDATA[7] == $past(FLAG); endproperty
    a_frd: assert property (p_frd) else $error("flag read");
    property p_ctl; rd_ctl |=> (RDATA & 8'h7A) == 8'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl spare bits");
    property p_idle; !BUS.rd |=> RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_unm; BUS.rd && !hit |=> RDATA == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_sts; BUS.rd && BUS.addr == 8'hD0 |=> RDATA[7:3] == 5'h00; endproperty
    a_sts: assert property (p_sts) else $error("status spare bits");
    property p_fall; $fell(IRQ) |-> $past(BUS.wr) || $past(BUS.wr, 2); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped alone");
    property p_msk; BUS.wr && BUS.addr == 8'hD1 && BUS.wdata == 8'h00 |=> ##1 !IRQ;
    endproperty
    a_msk: assert property (p_msk) else $error("irq while masked");
endmodule
bind tmr_core tmr_core_asserts chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .BUS(BUS),
    .RDATA(RDATA), .CAP(CAP), .FLAG(FLAG), .IRQ(IRQ));

/* hw/tmr_core.sv */
// 16-bit timer with prescaler, reload/compare pair and register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "tmr_defines.svh"
// Notes on behaviour
// RULE1 - reload enable 0 blocks any reload; 1 lets reload events load counter
// RULE2 - prescale codes 0..7 divide clock by 1,4,16,32,64,128,256,512
// RULE3 - capture auto-clear zeros counter on each capture event
// RULE4 - capture auto-clear acts only in auto-reload mode
// RULE5 - match auto-clear zeros counter after compare match
// RULE6 - match auto-clear acts only in compare mode
// RULE7 - trigger select: overflow, capture 0, capture 1, capture 2
// RULE8 - two reload/compare bytes form one 16-bit compare or reload value
// RULE9 - counter is 16 bits, accessed as low and high byte registers
// RULE10 - software should stop the timer before byte access to counter
// RULE11 - auto-reload mode loads reload value on the selected event
// RULE12 - with capture auto-clear a capture only zeros, never reloads
// RULE13 - mode, reload/compare and counter bytes reset to zero
// RULE14 - run bit clear holds count; set lets ticks advance it (here a capture still clears or reloads a stopped count)
// RULE15 - mode bit 0 auto-reload, 1 compare
// RULE16 - overflow flag set on overflow or match, cleared only by software
// RULE17 - compare mode detects counter equal to compare value, sets flag
// RULE18 - counter adds one per tick, wraps FFFF to 0000 with overflow event
module tmr_core (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // register port
    input wire tmr_pkg::bus_req_s BUS,
    output logic [7:0] RDATA,
    // capture event strobes from the capture channels
    input wire tmr_pkg::cap_evt_s CAP,
    // flag and interrupt
    output logic FLAG,
    output logic IRQ
);
    import tmr_pkg::*;

    // register contents
    logic [7:0] mode_ff;
    logic [7:0] rcmp_lo_ff;
    logic [7:0] rcmp_hi_ff;
    logic [2:0] mask_ff;
    logic [15:0] cnt_ff;
    logic [8:0] pre_ff;
    logic run_ff;
    logic cmp_mode_ff;
    logic flag_ff;
    logic [2:0] stat_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;

    // fields of the mode register
    wire reload_enable = mode_ff[`BIT_RELOAD_EN];
    wire [2:0] prescale_select = mode_ff[`PRE_HI:`PRE_LO];
    wire capture_auto_clear = mode_ff[`BIT_CAP_CLR];
    wire match_auto_clear = mode_ff[`BIT_MATCH_CLR];
    wire [1:0] reload_trigger_select = mode_ff[`TRIG_HI:`TRIG_LO];

    // register write decode
    wire wr_mode = BUS.wr && (BUS.addr == `ADDR_MODE);
    wire wr_rlo = BUS.wr && (BUS.addr == `ADDR_RCMP_LO);
    wire wr_rhi = BUS.wr && (BUS.addr == `ADDR_RCMP_HI);
    wire wr_clo = BUS.wr && (BUS.addr == `ADDR_CNT_LO);
    wire wr_chi = BUS.wr && (BUS.addr == `ADDR_CNT_HI);
    wire wr_ctrl = BUS.wr && (BUS.addr == `ADDR_CTRL);
    wire wr_stat = BUS.wr && (BUS.addr == `ADDR_IRQ_STAT);
    wire wr_mask = BUS.wr && (BUS.addr == `ADDR_IRQ_MASK);

    // write data fields
    wire [2:0] wdata_stat = BUS.wdata[`STAT_HI:`STAT_LO];
    wire wdata_flag = BUS.wdata[`BIT_FLAG];
    wire wdata_run = BUS.wdata[`BIT_RUN];
    wire wdata_mode = BUS.wdata[`BIT_MODE];

    // mode register
    tmr_byte_reg #(.W(8)) u_mode (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .we(wr_mode),
        .d(BUS.wdata),
        .q(mode_ff)
    ); // [RULE13]

    // reload/compare low byte
    tmr_byte_reg #(.W(8)) u_rcmp_lo (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .we(wr_rlo),
        .d(BUS.wdata),
        .q(rcmp_lo_ff)
    ); // [RULE13]

    // reload/compare high byte
    tmr_byte_reg #(.W(8)) u_rcmp_hi (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .we(wr_rhi),
        .d(BUS.wdata),
        .q(rcmp_hi_ff)
    ); // [RULE13]

    // interrupt mask
    tmr_byte_reg #(.W(3)) u_mask (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .we(wr_mask),
        .d(wdata_stat),
        .q(mask_ff)
    );

    // prescaler end count for the selected divide ratio
    logic [8:0] pre_last;
    always_comb begin
        case (prescale_select) // [RULE2]
            `DIV_1: pre_last = `PRE_LAST_1;
            `DIV_4: pre_last = `PRE_LAST_4;
            `DIV_16: pre_last = `PRE_LAST_16;
            `DIV_32: pre_last = `PRE_LAST_32;
            `DIV_64: pre_last = `PRE_LAST_64;
            `DIV_128: pre_last = `PRE_LAST_128;
            `DIV_256: pre_last = `PRE_LAST_256;
            default: pre_last = `PRE_LAST_512;
        endcase
    end

    // prescaler and counter tick
    wire [15:0] rcmp = {rcmp_hi_ff, rcmp_lo_ff}; // [RULE8]
    wire pre_wrap = (pre_ff >= pre_last);
    wire tick = run_ff && pre_wrap; // [RULE14]
    wire [8:0] nxt_pre = (!run_ff || pre_wrap) ? `PRE_ZERO : pre_ff + `PRE_ONE;

    // overflow, match and capture events
    // match counts only on a tick so a held count cannot retrigger
    wire ovf = tick && (cnt_ff == `CNT_MAX); // [RULE18]
    wire match = cmp_mode_ff && run_ff && (cnt_ff == rcmp); // [RULE17]
    wire match_evt = match && tick;
    wire any_cap = |CAP.cap;
    // capture clear is not gated by run, the channels sample the count anyway
    wire cap_clr = !cmp_mode_ff && capture_auto_clear && any_cap; // [RULE3] [RULE4]
    wire match_clr = cmp_mode_ff && match_auto_clear && match_evt; // [RULE5] [RULE6]

    // reload trigger select
    logic trig;
    always_comb begin
        case (reload_trigger_select) // [RULE7]
            `TRIG_OVF: trig = ovf;
            `TRIG_CAP0: trig = CAP.cap[`CAP_CH0];
            `TRIG_CAP1: trig = CAP.cap[`CAP_CH1];
            default: trig = CAP.cap[`CAP_CH2];
        endcase
    end

    // capture with auto-clear never reloads
    wire trig_is_cap = (reload_trigger_select != `TRIG_OVF);
    wire reload = !cmp_mode_ff && reload_enable && trig
        && !(capture_auto_clear && trig_is_cap); // [RULE1] [RULE11] [RULE12]

    // next counter value, a software byte write wins
    // byte writes to a running counter can tear, so software stops it first
    logic [15:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        if (tick) begin
            nxt_cnt = cnt_ff + `CNT_ONE; // [RULE18]
        end
        if (match_clr || cap_clr) begin
            nxt_cnt = `CNT_ZERO;
        end else if (reload) begin
            nxt_cnt = rcmp; // [RULE11]
        end
        if (wr_clo) begin
            nxt_cnt[`CNT_LO_MSB:`CNT_LO_LSB] = BUS.wdata; // [RULE9]
        end
        if (wr_chi) begin
            nxt_cnt[`CNT_HI_MSB:`CNT_HI_LSB] = BUS.wdata; // [RULE9]
        end
    end

    // counter register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_ff <= `CNT_ZERO; // [RULE13]
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // prescaler register, held at zero while stopped
    // a restart thus begins with a whole tick period
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_ff <= `PRE_ZERO;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // run and mode bits of the control register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_ff <= 1'h0;
            cmp_mode_ff <= 1'h0;
        end else if (wr_ctrl) begin
            run_ff <= wdata_run; // [RULE14]
            cmp_mode_ff <= wdata_mode; // [RULE15]
        end
    end

    // overflow flag: software may clear it, a same-cycle event wins
    wire flag_evt = ovf || match_evt;
    wire nxt_flag = flag_evt || (wr_ctrl ? wdata_flag : flag_ff); // [RULE16]
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flag_ff <= 1'h0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // sticky status, write one to clear, a same-cycle event wins
    // status bits: overflow, match, capture clear
    wire [2:0] evts = {cap_clr, match_evt, ovf};
    wire [2:0] nxt_stat = evts | (wr_stat ? (stat_ff & ~wdata_stat) : stat_ff);
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_ff <= `STAT_ZERO;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // level interrupt while an unmasked status bit is set
    // uses the next status so a clear drops the line with the status
    wire nxt_irq = |(nxt_stat & mask_ff);
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_ff <= 1'h0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // readback words
    wire [7:0] ctrl_word = {flag_ff, `CTRL_PAD4, run_ff, 1'h0, cmp_mode_ff};
    wire [7:0] stat_word = {`STAT_PAD, stat_ff};
    wire [7:0] mask_word = {`STAT_PAD, mask_ff};

    // read data mux, zero when no read is under way
    logic [7:0] nxt_rdata;
    always_comb begin
        case (BUS.addr)
            `ADDR_MODE: nxt_rdata = mode_ff;
            `ADDR_RCMP_LO: nxt_rdata = rcmp_lo_ff;
            `ADDR_RCMP_HI: nxt_rdata = rcmp_hi_ff;
            `ADDR_CNT_LO: nxt_rdata = cnt_ff[`CNT_LO_MSB:`CNT_LO_LSB];
            `ADDR_CNT_HI: nxt_rdata = cnt_ff[`CNT_HI_MSB:`CNT_HI_LSB];
            `ADDR_CTRL: nxt_rdata = ctrl_word;
            `ADDR_IRQ_STAT: nxt_rdata = stat_word;
            `ADDR_IRQ_MASK: nxt_rdata = mask_word;
            default: nxt_rdata = `BYTE_ZERO;
        endcase
        if (!BUS.rd) begin
            nxt_rdata = `BYTE_ZERO;
        end
    end

    // read data register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= `BYTE_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;
    assign FLAG = flag_ff;
    assign IRQ = irq_ff;
endmodule

// software register with write enable, cleared by reset
module tmr_byte_reg #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // write port
    input wire logic we,
    input wire logic [W-1:0] d,
    // stored value
    output logic [W-1:0] q
);
    logic [W-1:0] q_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_ff <= '0;
        end else if (we) begin
            q_ff <= d;
        end
    end

    assign q = q_ff;
endmodule

/* hw/tmr_defines.svh */
// register offsets, field positions and timing constants of the reload/compare timer
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define ADDR_MODE 8'hC9
`define ADDR_RCMP_LO 8'hCA
`define ADDR_RCMP_HI 8'hCB
`define ADDR_CNT_LO 8'hCC
`define ADDR_CNT_HI 8'hCD
`define ADDR_CTRL 8'hC8
`define ADDR_IRQ_STAT 8'hD0
`define ADDR_IRQ_MASK 8'hD1
`define BIT_RELOAD_EN 7
`define BIT_CAP_CLR 3
`define BIT_MATCH_CLR 2
`define BIT_FLAG 7
`define BIT_RUN 2
`define BIT_MODE 0
`define BYTE_ZERO 8'h00
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hFFFF
`define PRE_ZERO 9'h000
`define PRE_ONE 9'h001
`define IRQ_OVF 0
`define IRQ_MATCH 1
`define IRQ_CAP_CLR 2
`define PRE_HI 6
`define PRE_LO 4
`define TRIG_HI 1
`define TRIG_LO 0
`define TRIG_OVF 2'h0
`define TRIG_CAP0 2'h1
`define TRIG_CAP1 2'h2
`define CAP_CH0 0
`define CAP_CH1 1
`define CAP_CH2 2
`define DIV_1 3'h0
`define DIV_4 3'h1
`define DIV_16 3'h2
`define DIV_32 3'h3
`define DIV_64 3'h4
`define DIV_128 3'h5
`define DIV_256 3'h6
`define PRE_LAST_1 9'h000
`define PRE_LAST_4 9'h003
`define PRE_LAST_16 9'h00F
`define PRE_LAST_32 9'h01F
`define PRE_LAST_64 9'h03F
`define PRE_LAST_128 9'h07F
`define PRE_LAST_256 9'h0FF
`define PRE_LAST_512 9'h1FF
`define STAT_HI 2
`define STAT_LO 0
`define STAT_ZERO 3'h0
`define STAT_PAD 5'h00
`define CTRL_PAD4 4'h0
`define CNT_LO_MSB 7
`define CNT_LO_LSB 0
`define CNT_HI_MSB 15
`define CNT_HI_LSB 8
`endif

/* hw/tmr_pkg.sv */
// types shared by the reload/compare timer
package tmr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic [2:0] cap;
    } cap_evt_s;
endpackage
